// File: rtl/afg_cfg.svh
// Constants of the result framer and general pin block.
`ifndef AFG_CFG_SVH
`define AFG_CFG_SVH

`define AFG_CFG_TS       0
`define AFG_CFG_DATA_COUNTER_ENABLE     1
`define AFG_CFG_IM_LO    2
`define AFG_CFG_CM       4
`define AFG_CFG_DIR_LO   5
`define AFG_CFG_VAL_LO   8
`define AFG_CFG_SEL      11
`define AFG_CFG_REF      12
`define AFG_CFG_MUX_LO   13
`define AFG_CFG_RESET    16'h0000

`define AFG_IM_INV       2'h1
`define AFG_IM_CRC       2'h2
`define AFG_CRC_POLY     16'h1021
`define AFG_CRC_INIT     16'hFFFF

`define AFG_ADR_CMD      4'h0
`define AFG_ADR_RESULT   4'h4
`define AFG_ADR_STATUS   4'h8
`define AFG_ADR_CFG      4'hC
`define AFG_MAX_RETRY    2'h3

`endif

// File: rtl/afg_pkg.sv
// Types and frame helpers shared by both ends of the result link.
`default_nettype none
`include "afg_cfg.svh"
package afg_pkg;
    typedef enum logic [2:0] {
        AFG_OP_NOP, AFG_OP_RESET, AFG_OP_START, AFG_OP_SLEEP,
        AFG_OP_WRCFG, AFG_OP_RDDATA, AFG_OP_RDREG
    } afg_op_t;

    typedef logic [5:0][7:0] afg_bytes_t;

    typedef struct packed {
        afg_bytes_t b;
        logic [2:0] len;
    } afg_frame_t;

    // One byte into the checksum, most significant bit first.
    function automatic logic [15:0] afg_crc_byte(input logic [15:0] c_in,
                                                 input logic [7:0]  d);
        logic [15:0] c;
        c = c_in;
        for (int i = 7; i >= 0; i--) begin
            if (c[15] ^ d[i]) begin
                c = {c[14:0], 1'b0} ^ `AFG_CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : afg_crc_byte

    // Counter, low byte, high byte, then the protection bytes.
    function automatic afg_frame_t afg_build(input logic        has_cnt,
                                             input logic [7:0]  cnt,
                                             input logic [15:0] w,
                                             input logic [1:0]  mode);
        afg_frame_t  f;
        int          n;
        logic [15:0] c;
        f = '0;
        n = 0;
        c = `AFG_CRC_INIT;
        if (has_cnt) begin
            f.b[0] = cnt;
            n = 1;
        end
        f.b[n]     = w[7:0];
        f.b[n + 1] = w[15:8];
        n = n + 2;
        f.len = 3'(n);
        if (mode == `AFG_IM_INV) begin
            for (int i = 0; i < 3; i++) begin
                if (i < n) begin
                    f.b[n + i] = ~f.b[i];
                end
            end
            f.len = 3'(2 * n);
        end else if (mode == `AFG_IM_CRC) begin
            for (int i = 0; i < 3; i++) begin
                if (i < n) begin
                    c = afg_crc_byte(c, f.b[i]);
                end
            end
            f.b[n]     = c[15:8];
            f.b[n + 1] = c[7:0];
            f.len = 3'(n + 2);
        end
        return f;
    endfunction : afg_build
endpackage : afg_pkg
`default_nettype wire

// File: rtl/afg_link_if.sv
// Command and byte-return link between host controller and device.
`default_nettype none
interface afg_link_if;
    import afg_pkg::*;
    logic        cmd_valid;
    afg_op_t     cmd_op;
    logic [15:0] cmd_arg;
    logic        tx_valid;
    logic [7:0]  tx_byte;

    modport dev  (input cmd_valid, cmd_op, cmd_arg, output tx_valid, tx_byte);
    modport host (output cmd_valid, cmd_op, cmd_arg, input tx_valid, tx_byte);
endinterface : afg_link_if
`default_nettype wire

// File: rtl/afg_dev.sv
// Device end: conversion control, result framing, counter and general pins.
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`default_nettype none
`include "afg_cfg.svh"
module afg_dev (
    input  wire logic         mclk_i,
    input  wire logic         reset_i,
    afg_link_if.dev           link,
    input  wire logic [15:0]  adc_code_i,
    input  wire logic [13:0]  temp_code_i,
    input  wire logic         conv_done_i,
    output logic              conv_start_o,
    output logic              converting_o,
    output logic              temp_mode_o,
    output logic              int_ref_o,
    output logic [2:0]        mux_sel_o,
    input  wire logic [2:0]   gpio_in_i,
    output logic [2:0]        gpio_out_o,
    output logic [2:0]        gpio_oe_o
);
    import afg_pkg::*;

    typedef enum {AFG_ST_IDLE, AFG_ST_CONV} afg_dev_st_t;

    afg_dev_st_t st,        next_st;
    logic [15:0] cfg,       next_cfg;
    logic        sleep_pend, next_sleep_pend;
    logic [7:0]  cnt,       next_cnt;
    logic [15:0] result,    next_result;
    logic        ready_n,   next_ready_n;
    afg_bytes_t  frame,     next_frame;
    logic [2:0]  flen,      next_flen;
    logic [2:0]  fidx,      next_fidx;
    logic        sending,   next_sending;
    logic        tx_valid,  next_tx_valid;
    logic [7:0]  tx_byte,   next_tx_byte;
    logic        conv_start, next_conv_start;
    logic [2:0]  gsync1,    next_gsync1;
    logic [2:0]  gsync2,    next_gsync2;

    logic        soft_rst;
    logic [15:0] reg_word;
    afg_frame_t  data_fr;
    afg_frame_t  reg_fr;

    // A reset command takes effect in the cycle it arrives, mid-frame too.
    assign soft_rst = link.cmd_valid && (link.cmd_op == AFG_OP_RESET);

    always_comb begin
        reg_word = cfg;
        for (int i = 0; i < 3; i++) begin
            if (!cfg[`AFG_CFG_DIR_LO + i]) begin
                reg_word[`AFG_CFG_VAL_LO + i] = gsync2[i];
            end
        end
        data_fr = afg_build(cfg[`AFG_CFG_DATA_COUNTER_ENABLE], cnt, result,
                            cfg[`AFG_CFG_IM_LO +: 2]);
        reg_fr  = afg_build(1'b0, 8'h00, reg_word, cfg[`AFG_CFG_IM_LO +: 2]);
    end

    always_comb begin
        next_st         = st;
        next_cfg        = cfg;
        next_sleep_pend = sleep_pend;
        next_cnt        = cnt;
        next_result     = result;
        next_ready_n    = ready_n;
        next_frame      = frame;
        next_flen       = flen;
        next_fidx       = fidx;
        next_sending    = sending;
        next_tx_valid   = 1'b0;
        next_tx_byte    = tx_byte;
        next_conv_start = 1'b0;

        // Pins are asynchronous, so two flip-flops stand before any logic.
        next_gsync1     = gpio_in_i;
        next_gsync2     = gsync1;

        // Holding the counter at zero while disabled lets clear-then-set restart it.
        if (!cfg[`AFG_CFG_DATA_COUNTER_ENABLE]) begin
            next_cnt = 8'h00;
        end

        if (sending) begin
            next_tx_valid = 1'b1;
            next_tx_byte  = frame[fidx];
            next_fidx     = fidx + 3'h1;
            if (fidx + 3'h1 == flen) begin
                next_sending = 1'b0;
            end
        end

        if (link.cmd_valid) begin
            case (link.cmd_op)
                AFG_OP_START: begin
                    next_conv_start = 1'b1;
                    next_st         = AFG_ST_CONV;
                    next_sleep_pend = 1'b0;
                end
                AFG_OP_SLEEP: begin
                    if (st == AFG_ST_CONV) begin
                        next_sleep_pend = 1'b1;
                    end
                end
                AFG_OP_WRCFG: begin
                    next_cfg = link.cmd_arg;
                end
                AFG_OP_RDDATA: begin
                    if (!sending) begin
                        next_frame   = data_fr.b;
                        next_flen    = data_fr.len;
                        next_fidx    = 3'h0;
                        next_sending = 1'b1;
                        next_ready_n = 1'b1;
                    end
                end
                AFG_OP_RDREG: begin
                    if (!sending) begin
                        next_frame   = reg_fr.b;
                        next_flen    = reg_fr.len;
                        next_fidx    = 3'h0;
                        next_sending = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // A completing conversion outranks a read latched in the same cycle,
        // so the new result is never hidden behind a stale ready level.
        if (st == AFG_ST_CONV && conv_done_i && !next_conv_start) begin
            if (cfg[`AFG_CFG_TS]) begin
                next_result = {temp_code_i, 2'b00};
            end else begin
                next_result = adc_code_i;
            end
            if (cfg[`AFG_CFG_DATA_COUNTER_ENABLE]) begin
                next_cnt = cnt + 8'h01;
            end
            next_ready_n = 1'b0;
            if (cfg[`AFG_CFG_CM] && !sleep_pend) begin
                next_conv_start = 1'b1;
            end else begin
                next_st         = AFG_ST_IDLE;
                next_sleep_pend = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i || soft_rst) begin
            st         <= AFG_ST_IDLE;
            cfg        <= `AFG_CFG_RESET;
            sleep_pend <= 1'b0;
            cnt        <= 8'h00;
            result     <= 16'h0000;
            ready_n    <= 1'b1;
            frame      <= '0;
            flen       <= 3'h0;
            fidx       <= 3'h0;
            sending    <= 1'b0;
            tx_valid   <= 1'b0;
            tx_byte    <= 8'h00;
            conv_start <= 1'b0;
        end else begin
            st         <= next_st;
            cfg        <= next_cfg;
            sleep_pend <= next_sleep_pend;
            cnt        <= next_cnt;
            result     <= next_result;
            ready_n    <= next_ready_n;
            frame      <= next_frame;
            flen       <= next_flen;
            fidx       <= next_fidx;
            sending    <= next_sending;
            tx_valid   <= next_tx_valid;
            tx_byte    <= next_tx_byte;
            conv_start <= next_conv_start;
        end

        // The pin synchronisers follow only the reset input, not the command.
        if (reset_i) begin
            gsync1 <= 3'h0;
            gsync2 <= 3'h0;
        end else begin
            gsync1 <= next_gsync1;
            gsync2 <= next_gsync2;
        end
    end

    assign link.tx_valid = tx_valid;
    assign link.tx_byte  = tx_byte;
    assign conv_start_o  = conv_start;
    assign converting_o  = (st == AFG_ST_CONV);
    assign temp_mode_o   = cfg[`AFG_CFG_TS];
    // Temperature mode overrides the source and reference fields.
    assign int_ref_o     = cfg[`AFG_CFG_TS] | cfg[`AFG_CFG_REF];
    assign mux_sel_o     = cfg[`AFG_CFG_TS] ? 3'h0 : cfg[`AFG_CFG_MUX_LO +: 3];
    assign gpio_oe_o     = cfg[`AFG_CFG_DIR_LO +: 3];
    // The shared pin carries the active-low ready level only when selected.
    always_comb begin
        gpio_out_o = cfg[`AFG_CFG_VAL_LO +: 3];
        if (cfg[`AFG_CFG_SEL]) begin
            gpio_out_o[2] = ready_n;
        end
    end
endmodule : afg_dev
`default_nettype wire

// File: rtl/afg_host.sv
// Host end: Wishbone command registers, frame receive and integrity check.
`default_nettype none
`include "afg_cfg.svh"
module afg_host (
    input  wire logic         mclk_i,
    input  wire logic         reset_i,
    afg_link_if.host          link,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [3:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic [31:0]       wb_dat_o,
    output logic              wb_ack_o
);
    import afg_pkg::*;

    typedef enum {AFG_H_IDLE, AFG_H_RECV} afg_host_st_t;

    afg_host_st_t st,       next_st;
    logic         ack,      next_ack;
    logic [31:0]  rdat,     next_rdat;
    logic         cmd_v,    next_cmd_v;
    afg_op_t      cmd_op,   next_cmd_op;
    logic [15:0]  cmd_arg,  next_cmd_arg;
    logic [15:0]  shadow,   next_shadow;
    afg_bytes_t   rx,       next_rx;
    logic [2:0]   rx_n,     next_rx_n;
    logic [1:0]   retry,    next_retry;
    logic [7:0]   res_cnt,  next_res_cnt;
    logic [15:0]  res_word, next_res_word;
    logic [7:0]   last_cnt, next_last_cnt;
    logic         have_last, next_have_last;
    logic         integ_err, next_integ_err;
    logic         stale,    next_stale;
    logic         missed,   next_missed;
    logic         res_new,  next_res_new;
    logic         is_data;
    logic         has_cnt;
    logic         wr_cmd;
    logic [7:0]   got_cnt;
    logic [15:0]  got_word;
    afg_frame_t   expect_fr;

    assign is_data = (cmd_op == AFG_OP_RDDATA);
    assign has_cnt = is_data && shadow[`AFG_CFG_DATA_COUNTER_ENABLE];
    assign wr_cmd  = wb_cyc_i && wb_stb_i && !ack && wb_we_i &&
                     (wb_adr_i == `AFG_ADR_CMD) && (&wb_sel_i[2:0]);

    always_comb begin
        got_cnt   = has_cnt ? rx[0] : 8'h00;
        got_word  = has_cnt ? {rx[2], rx[1]} : {rx[1], rx[0]};
        expect_fr = afg_build(has_cnt, got_cnt, got_word,
                              shadow[`AFG_CFG_IM_LO +: 2]);
    end

    always_comb begin
        next_st        = st;
        next_ack       = wb_cyc_i && wb_stb_i && !ack;
        next_rdat      = 32'h0000_0000;
        next_cmd_v     = 1'b0;
        next_cmd_op    = cmd_op;
        next_cmd_arg   = cmd_arg;
        next_shadow    = shadow;
        next_rx        = rx;
        next_rx_n      = rx_n;
        next_retry     = retry;
        next_res_cnt   = res_cnt;
        next_res_word  = res_word;
        next_last_cnt  = last_cnt;
        next_have_last = have_last;
        next_integ_err = integ_err;
        next_stale     = stale;
        next_missed    = missed;
        next_res_new   = res_new;

        case (wb_adr_i)
            `AFG_ADR_RESULT: next_rdat = {8'h00, res_cnt, res_word};
            `AFG_ADR_STATUS: next_rdat = {27'h0, res_new, missed, stale,
                                          integ_err, st == AFG_H_RECV};
            `AFG_ADR_CFG:    next_rdat = {16'h0000, shadow};
            default:         next_rdat = 32'h0000_0000;
        endcase
        if (wb_cyc_i && wb_stb_i && !ack && !wb_we_i &&
            wb_adr_i == `AFG_ADR_RESULT) begin
            next_res_new = 1'b0;
        end

        if (wr_cmd && st == AFG_H_IDLE) begin
            next_cmd_v   = 1'b1;
            next_cmd_op  = afg_op_t'(wb_dat_i[18:16]);
            next_cmd_arg = wb_dat_i[15:0];
            case (afg_op_t'(wb_dat_i[18:16]))
                AFG_OP_RESET: begin
                    next_shadow    = `AFG_CFG_RESET;
                    next_have_last = 1'b0;
                end
                AFG_OP_WRCFG: begin
                    next_shadow = wb_dat_i[15:0];
                    if (!wb_dat_i[`AFG_CFG_DATA_COUNTER_ENABLE]) begin
                        next_have_last = 1'b0;
                    end
                end
                AFG_OP_RDDATA, AFG_OP_RDREG: begin
                    // Bytes left from a longer earlier frame would fail the compare.
                    next_rx    = '0;
                    next_st    = AFG_H_RECV;
                    next_rx_n  = 3'h0;
                    next_retry = 2'h0;
                end
                default: begin
                end
            endcase
        end

        if (st == AFG_H_RECV && link.tx_valid) begin
            next_rx[rx_n] = link.tx_byte;
            next_rx_n     = rx_n + 3'h1;
        end

        if (st == AFG_H_RECV && !link.tx_valid && rx_n != 3'h0 &&
            rx_n == expect_fr.len) begin
            next_rx_n = 3'h0;
            if (expect_fr.b != rx && retry != `AFG_MAX_RETRY) begin
                next_retry = retry + 2'h1;
                next_cmd_v = 1'b1;
            end else begin
                next_st        = AFG_H_IDLE;
                next_integ_err = (expect_fr.b != rx);
                next_res_word  = got_word;
                next_res_cnt   = got_cnt;
                next_res_new   = 1'b1;
                if (has_cnt) begin
                    next_stale     = have_last && (got_cnt == last_cnt);
                    next_missed    = have_last && (got_cnt != last_cnt) &&
                                     (got_cnt != last_cnt + 8'h01);
                    next_last_cnt  = got_cnt;
                    next_have_last = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st        <= AFG_H_IDLE;
            ack       <= 1'b0;
            rdat      <= 32'h0000_0000;
            cmd_v     <= 1'b0;
            cmd_op    <= AFG_OP_NOP;
            cmd_arg   <= 16'h0000;
            shadow    <= `AFG_CFG_RESET;
            rx        <= '0;
            rx_n      <= 3'h0;
            retry     <= 2'h0;
            res_cnt   <= 8'h00;
            res_word  <= 16'h0000;
            last_cnt  <= 8'h00;
            have_last <= 1'b0;
            integ_err <= 1'b0;
            stale     <= 1'b0;
            missed    <= 1'b0;
            res_new   <= 1'b0;
        end else begin
            st        <= next_st;
            ack       <= next_ack;
            rdat      <= next_rdat;
            cmd_v     <= next_cmd_v;
            cmd_op    <= next_cmd_op;
            cmd_arg   <= next_cmd_arg;
            shadow    <= next_shadow;
            rx        <= next_rx;
            rx_n      <= next_rx_n;
            retry     <= next_retry;
            res_cnt   <= next_res_cnt;
            res_word  <= next_res_word;
            last_cnt  <= next_last_cnt;
            have_last <= next_have_last;
            integ_err <= next_integ_err;
            stale     <= next_stale;
            missed    <= next_missed;
            res_new   <= next_res_new;
        end
    end

    assign link.cmd_valid = cmd_v;
    assign link.cmd_op    = cmd_op;
    assign link.cmd_arg   = cmd_arg;
    assign wb_ack_o       = ack;
    assign wb_dat_o       = rdat;
endmodule : afg_host
`default_nettype wire

// File: testbench/afg_checker.sv
// Concurrent checks on the command and byte-return link between the two ends.
`default_nettype none
`include "afg_cfg.svh"
module afg_checker (
    input wire logic             mclk_i,
    input wire logic             reset_i,
    input wire logic             cmd_valid,
    input wire afg_pkg::afg_op_t cmd_op,
    input wire logic [15:0]      cmd_arg,
    input wire logic             tx_valid,
    input wire logic [7:0]       tx_byte
);
    import afg_pkg::*;
    logic [15:0] cfg;
    logic        data_rd;
    logic [2:0]  idx;
    logic [2:0]  nb;
    logic [2:0]  exp_len;
    logic [7:0]  seen [6];
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // A mirror of the written configuration lets the frame length be predicted.
    always_ff @(posedge mclk_i) begin
        if (reset_i || (cmd_valid && cmd_op == AFG_OP_RESET)) begin
            cfg <= 16'h0000;
        end else if (cmd_valid && cmd_op == AFG_OP_WRCFG) begin
            cfg <= cmd_arg;
        end
        if (cmd_valid && (cmd_op == AFG_OP_RDDATA || cmd_op == AFG_OP_RDREG)) begin
            data_rd <= (cmd_op == AFG_OP_RDDATA);
        end
        idx <= (tx_valid && !reset_i) ? idx + 3'h1 : 3'h0;
        if (tx_valid) begin
            seen[idx] <= tx_byte;
        end
    end
    assign nb = (data_rd && cfg[1]) ? 3'h3 : 3'h2;
    assign exp_len = (cfg[3:2] == `AFG_IM_INV) ? 3'(2 * nb) :
                     (cfg[3:2] == `AFG_IM_CRC) ? nb + 3'h2 : nb;
    sequence s_read_cmd;
        cmd_valid && (cmd_op == AFG_OP_RDDATA || cmd_op == AFG_OP_RDREG);
    endsequence
    sequence s_frame_start;
        !tx_valid ##1 tx_valid ##1 tx_valid;
    endsequence
    property p_answer; s_read_cmd |-> ##1 s_frame_start; endproperty
    a_answer: assert property (p_answer) else $error("read answered late");
    property p_origin;
        $rose(tx_valid) |-> $past(cmd_valid, 2) &&
            ($past(cmd_op, 2) == AFG_OP_RDDATA || $past(cmd_op, 2) == AFG_OP_RDREG);
    endproperty
    a_origin: assert property (p_origin) else $error("bytes sent unasked");
    property p_len; $fell(tx_valid) |-> idx == exp_len; endproperty
    a_len: assert property (p_len) else $error("frame length wrong");
    property p_inv;
        tx_valid && cfg[3:2] == `AFG_IM_INV && idx >= nb |-> tx_byte == ~seen[idx - nb];
    endproperty
    a_inv: assert property (p_inv) else $error("inverted copy wrong");
    property p_temp;
        tx_valid && data_rd && cfg[0] && idx == {2'b00, cfg[1]} |-> tx_byte[1:0] == 2'b00;
    endproperty
    a_temp: assert property (p_temp) else $error("temperature low bits set");
    property p_half; tx_valid |-> !cmd_valid; endproperty
    a_half: assert property (p_half) else $error("command during frame");
    property p_pulse; cmd_valid |=> !cmd_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("command longer than a cycle");
    property p_gap; $fell(tx_valid) |-> !tx_valid [*2]; endproperty
    a_gap: assert property (p_gap) else $error("bytes after frame end");
endmodule : afg_checker
`default_nettype wire

// File: testbench/test_adc_result_framing_gpio.sv
// Bench joining both ends over the link and driving the host's Wishbone port.
`default_nettype none
`include "afg_cfg.svh"
module test_adc_result_framing_gpio import afg_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, done = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic        ack, cstart, conv, tmode, iref;
    logic [15:0] code = 16'h0000;
    logic [13:0] temp = 14'h0000;
    logic [13:0] tt [3] = '{14'h3B00, 14'h1000, 14'h0320};
    logic [2:0]  pin_in = 3'h0, mux, pout, poe;
    logic [7:0]  rx [$];
    logic [7:0]  fr [$];
    int          miscompares = 0, checks = 0, cyc_n = 0;
    afg_link_if link ();
    afg_dev afg_dev_inst (.mclk_i(mclk_i), .reset_i(reset_i), .link(link), .adc_code_i(code),
        .temp_code_i(temp), .conv_done_i(done), .conv_start_o(cstart), .converting_o(conv),
        .temp_mode_o(tmode), .int_ref_o(iref), .mux_sel_o(mux), .gpio_in_i(pin_in),
        .gpio_out_o(pout), .gpio_oe_o(poe));
    afg_host afg_host_inst (.mclk_i(mclk_i), .reset_i(reset_i), .link(link), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack));
    afg_checker afg_checker_inst (.mclk_i(mclk_i), .reset_i(reset_i),
        .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op), .cmd_arg(link.cmd_arg),
        .tx_valid(link.tx_valid), .tx_byte(link.tx_byte));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    // Bytes are captured as sampled at the edge, before that edge's updates land.
    always @(posedge mclk_i) begin
        cyc_n <= cyc_n + 1;
        if (link.tx_valid === 1'b1) rx.push_back(link.tx_byte);
        if (cyc_n == 60000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    function automatic logic [15:0] crc(input logic [7:0] b [$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[k]) begin
            for (int i = 7; i >= 0; i--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k][i]) ? 16'h1021 : 16'h0000);
            end
        end
        return c;
    endfunction : crc
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // Leaves the last status word in q, read with busy clear or after 30 polls.
    task automatic cmd(input afg_op_t op, input logic [15:0] arg);
        int n;
        n = 0;
        wb(1'b1, `AFG_ADR_CMD, {13'h0000, op, arg});
        do begin
            wb(1'b0, `AFG_ADR_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 30);
    endtask : cmd
    task automatic convert(input logic [15:0] c, input logic [13:0] t);
        int n;
        n = 0;
        code <= c;
        temp <= t;
        while (conv !== 1'b1 && n < 20) begin
            @(posedge mclk_i);
            n++;
        end
        done <= 1'b1;
        @(posedge mclk_i);
        done <= 1'b0;
        repeat (3) @(posedge mclk_i);
    endtask : convert
    task automatic read_chk(input logic [7:0] cn, input logic [15:0] w, input logic [1:0] m,
                            input logic hc, input afg_op_t op);
        logic [15:0] c;
        int n;
        rx.delete();
        fr.delete();
        if (hc) fr.push_back(cn);
        fr.push_back(w[7:0]);
        fr.push_back(w[15:8]);
        n = fr.size();
        c = crc(fr);
        if (m == 2'h1) for (int i = 0; i < n; i++) fr.push_back(~fr[i]);
        if (m == 2'h2) begin
            fr.push_back(c[15:8]);
            fr.push_back(c[7:0]);
        end
        cmd(op, 16'h0000);
        chk("frame length", 32'(rx.size()), 32'(fr.size()));
        foreach (fr[k]) chk("frame byte", 32'(rx[k]), 32'(fr[k]));
    endtask : read_chk
    initial begin
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        wb(1'b0, `AFG_ADR_STATUS, 32'h0);
        chk("status", q, 32'h0);
        chk("pin enables", 32'(poe), 32'h0);
        wb(1'b1, 4'h2, 32'hFFFF_FFFF);
        wb(1'b0, 4'h2, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("test reset done");
        cmd(AFG_OP_WRCFG, 16'hE00B);
        chk("temp mode", 32'(tmode), 32'h1);
        chk("int ref", 32'(iref), 32'h1);
        chk("mux", 32'(mux), 32'h0);
        foreach (tt[i]) begin
            cmd(AFG_OP_START, 16'h0000);
            convert(16'h1234, tt[i]);
            read_chk(8'(i + 1), {tt[i], 2'b00}, 2'h2, 1'b1, AFG_OP_RDDATA);
            chk("status", {27'h0, q[4:0]}, 32'h10);
            wb(1'b0, `AFG_ADR_RESULT, 32'h0);
            chk("result", q, {8'h00, 8'(i + 1), tt[i], 2'b00});
        end
        read_chk(8'h03, {tt[2], 2'b00}, 2'h2, 1'b1, AFG_OP_RDDATA);
        chk("stale", 32'(q[2]), 32'h1);
        cmd(AFG_OP_WRCFG, 16'h0009);
        cmd(AFG_OP_WRCFG, 16'h000B);
        cmd(AFG_OP_START, 16'h0000);
        convert(16'h1234, 14'h0001);
        read_chk(8'h01, 16'h0004, 2'h2, 1'b1, AFG_OP_RDDATA);
        $display("test temperature and checksum done");
        cmd(AFG_OP_WRCFG, 16'h0564);
        chk("pin enables", 32'(poe), 32'h3);
        chk("pin outputs", 32'(pout[1:0]), 32'h1);
        read_chk(8'h00, 16'h0164, 2'h1, 1'b0, AFG_OP_RDREG);
        pin_in <= 3'h4;
        read_chk(8'h00, 16'h0564, 2'h1, 1'b0, AFG_OP_RDREG);
        cmd(AFG_OP_WRCFG, 16'h0880);
        chk("ready idle", 32'(pout[2]), 32'h1);
        cmd(AFG_OP_START, 16'h0000);
        convert(16'hA5C3, 14'h0000);
        chk("ready low", 32'(pout[2]), 32'h0);
        read_chk(8'h00, 16'hA5C3, 2'h0, 1'b0, AFG_OP_RDDATA);
        chk("ready high", 32'(pout[2]), 32'h1);
        cmd(AFG_OP_WRCFG, 16'h0080);
        chk("pin data", 32'(pout[2]), 32'h0);
        cmd(AFG_OP_WRCFG, 16'h0480);
        chk("pin data", 32'(pout[2]), 32'h1);
        $display("test pins done");
        cmd(AFG_OP_WRCFG, 16'h0012);
        cmd(AFG_OP_START, 16'h0000);
        repeat (255) convert(16'h0F0F, 14'h0000);
        read_chk(8'hFF, 16'h0F0F, 2'h0, 1'b1, AFG_OP_RDDATA);
        repeat (2) convert(16'h0F0F, 14'h0000);
        read_chk(8'h01, 16'h0F0F, 2'h0, 1'b1, AFG_OP_RDDATA);
        chk("missed", 32'(q[3]), 32'h1);
        cmd(AFG_OP_SLEEP, 16'h0000);
        chk("still converting", 32'(conv), 32'h1);
        convert(16'h0F0F, 14'h0000);
        chk("asleep", 32'({conv, cstart}), 32'h0);
        read_chk(8'h02, 16'h0F0F, 2'h0, 1'b1, AFG_OP_RDDATA);
        $display("test continuous and sleep done");
        cmd(AFG_OP_WRCFG, 16'h00E1);
        cmd(AFG_OP_START, 16'h0000);
        chk("converting", 32'(conv), 32'h1);
        cmd(AFG_OP_RESET, 16'h0000);
        chk("reset state", 32'({conv, tmode, poe}), 32'h0);
        $display("test command reset done");
        test_done();
    end
endmodule : test_adc_result_framing_gpio
`default_nettype wire
